// ==== design/draw_step_pkg.sv ====
/*
 * Shared definitions for the draw-and-step engine: register offsets,
 * reset values, field layouts and mode encodings.
 * Assumes a 32-bit APB register bus with byte strobes.
 */
package draw_step_pkg;
    // register byte offsets on the APB window
    localparam logic [7:0] OFS_OP = 8'h00;
    localparam logic [7:0] OFS_DST_X = 8'h04;
    localparam logic [7:0] OFS_DST_Y = 8'h08;
    localparam logic [7:0] OFS_DST_W = 8'h0C;
    localparam logic [7:0] OFS_DST_H = 8'h10;
    localparam logic [7:0] OFS_MSK_W = 8'h14;
    localparam logic [7:0] OFS_MSK_H = 8'h18;
    localparam logic [7:0] OFS_MSK_OX = 8'h1C;
    localparam logic [7:0] OFS_MSK_OY = 8'h20;
    localparam logic [7:0] OFS_STEP = 8'h24;
    localparam logic [7:0] OFS_STAT = 8'h28;
    // reset values
    localparam logic [5:0] OP_RST = 6'h00;
    localparam logic [15:0] COORD_RST = 16'h0000;
    localparam logic [15:0] DIM_RST = 16'h0FFF;
    localparam logic [31:0] STEP_RST = 32'h0000_0000;
    // function field value that selects draw-and-step
    localparam logic [1:0] FUNC_STEP = 2'h1;
    localparam logic [7:0] CODE_STOP = 8'h00;
    localparam int STEP_BYTES = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int MSB_LANE = 3;

    typedef enum logic [1:0] {MASK_OFF, MASK_BOUND, MASK_FULL} mask_mode_t;
    typedef enum logic [1:0] {DRAW_PLAIN, DRAW_FIRST_NULL, DRAW_LAST_NULL} draw_mode_t;

    // operation register: [5:4] draw mode, [3:2] mask mode, [1:0] function
    typedef struct packed {
        draw_mode_t dmode;
        mask_mode_t mmode;
        logic [1:0] func;
    } op_t;

    // one step code: [7:5] direction, [4] draw, [3:0] step count
    typedef struct packed {
        logic [2:0] dir;
        logic draw;
        logic [3:0] cnt;
    } step_code_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
    } pix_xy_t;
endpackage

// ==== design/draw_step_engine.sv ====
/*
 * Draw-and-step vector engine with destination and mask map scissor.
 * Registers sit behind an APB slave; pixel writes and mask fetches go
 * to a memory port on the same clock with simple req/ack handshakes.
 */
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module draw_step_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output var draw_step_pkg::pix_xy_t dst_xy,
    output logic dst_we,
    input wire logic dst_ready,
    output var draw_step_pkg::pix_xy_t mask_xy,
    output logic mask_req,
    input wire logic mask_ack,
    input wire logic mask_bit,
    output logic busy,
    output logic op_done
);
    import draw_step_pkg::*;

    typedef enum {S_IDLE, S_NEXT, S_PIXEL, S_MASK, S_WRITE, S_MOVE} state_t;

    state_t state_r;
    op_t op_r;
    logic [15:0] x_r, y_r, dst_w_r, dst_h_r, msk_w_r, msk_h_r, msk_ox_r, msk_oy_r;
    logic [31:0] codes_r;
    logic [3:0] cval_r;
    logic [1:0] idx_r;
    step_code_t code_r;
    logic [3:0] pix_r;
    pix_xy_t mxy_r;
    logic [31:0] rd_nxt;
    logic addr_ok, apb_wr, apb_setup_rd, step_wr, start;
    logic [15:0] mx_c, my_c, dx_c, dy_c;
    logic in_dest, in_mask, null_px, eligible, last_px, is_stop;

    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite && addr_ok;
    assign apb_setup_rd = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !addr_ok;
    assign step_wr = apb_wr && (paddr == OFS_STEP);
    // only the top byte lane starts; the engine must be idle
    assign start = step_wr && pstrb[MSB_LANE] && (state_r == S_IDLE)
                   && (op_r.func == FUNC_STEP);

    // address decode and read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_nxt = 32'h0000_0000;
        if (paddr == OFS_OP) begin
            rd_nxt = {26'h0000000, op_r};
        end else if (paddr == OFS_DST_X) begin
            rd_nxt = {16'h0000, x_r};
        end else if (paddr == OFS_DST_Y) begin
            rd_nxt = {16'h0000, y_r};
        end else if (paddr == OFS_DST_W) begin
            rd_nxt = {16'h0000, dst_w_r};
        end else if (paddr == OFS_DST_H) begin
            rd_nxt = {16'h0000, dst_h_r};
        end else if (paddr == OFS_MSK_W) begin
            rd_nxt = {16'h0000, msk_w_r};
        end else if (paddr == OFS_MSK_H) begin
            rd_nxt = {16'h0000, msk_h_r};
        end else if (paddr == OFS_MSK_OX) begin
            rd_nxt = {16'h0000, msk_ox_r};
        end else if (paddr == OFS_MSK_OY) begin
            rd_nxt = {16'h0000, msk_oy_r};
        end else if (paddr == OFS_STEP) begin
            rd_nxt = codes_r;
        end else if (paddr == OFS_STAT) begin
            rd_nxt[STAT_BUSY_BIT] = busy;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // read data latched in the setup cycle so it is a flop in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup_rd) begin
            prdata <= rd_nxt;
        end
    end

    // configuration registers; map sizes are size minus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r <= op_t'(OP_RST);
            dst_w_r <= DIM_RST;
            dst_h_r <= DIM_RST;
            msk_w_r <= DIM_RST;
            msk_h_r <= DIM_RST;
            msk_ox_r <= COORD_RST;
            msk_oy_r <= COORD_RST;
        end else if (apb_wr) begin
            if (paddr == OFS_OP) op_r <= op_t'(pwdata[5:0]);
            if (paddr == OFS_DST_W) dst_w_r <= pwdata[15:0];
            if (paddr == OFS_DST_H) dst_h_r <= pwdata[15:0];
            if (paddr == OFS_MSK_W) msk_w_r <= pwdata[15:0];
            if (paddr == OFS_MSK_H) msk_h_r <= pwdata[15:0];
            if (paddr == OFS_MSK_OX) msk_ox_r <= pwdata[15:0];
            if (paddr == OFS_MSK_OY) msk_oy_r <= pwdata[15:0];
        end
    end

    // step codes and which byte lanes actually carried a code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            codes_r <= STEP_RST;
            cval_r <= 4'h0;
        end else if (start) begin
            codes_r <= pwdata;
            cval_r <= pstrb;
        end
    end

    // direction decode: 0 is +x, then counter-clockwise in 45 degree steps
    always_comb begin
        dx_c = 16'h0000;
        dy_c = 16'h0000;
        case (code_r.dir)
            3'h0: dx_c = 16'h0001;
            3'h1: begin dx_c = 16'h0001; dy_c = 16'hFFFF; end
            3'h2: dy_c = 16'hFFFF;
            3'h3: begin dx_c = 16'hFFFF; dy_c = 16'hFFFF; end
            3'h4: dx_c = 16'hFFFF;
            3'h5: begin dx_c = 16'hFFFF; dy_c = 16'h0001; end
            3'h6: dy_c = 16'h0001;
            default: begin dx_c = 16'h0001; dy_c = 16'h0001; end
        endcase
    end

    // scissor tests; edges are inclusive, values with bit 15 set count as negative and fail
    assign mx_c = x_r - msk_ox_r;
    assign my_c = y_r - msk_oy_r;
    assign in_dest = !x_r[15] && !y_r[15] && (x_r <= dst_w_r)
                     && (y_r <= dst_h_r);
    assign in_mask = !mx_c[15] && !my_c[15] && (mx_c <= msk_w_r)
                     && (my_c <= msk_h_r);
    assign last_px = (pix_r == code_r.cnt);
    // null end pixels judged per code, not per register write
    assign null_px = ((op_r.dmode == DRAW_FIRST_NULL) && (pix_r == 4'h0))
                     || ((op_r.dmode == DRAW_LAST_NULL) && last_px);
    assign eligible = code_r.draw && !null_px && in_dest
                      && ((op_r.mmode == MASK_OFF) || in_mask);
    assign is_stop = (code_r == step_code_t'(CODE_STOP));

    // sequencer: one pixel per visit to S_PIXEL, lowest code first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            idx_r <= 2'h0;
            code_r <= step_code_t'(CODE_STOP);
            pix_r <= 4'h0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        state_r <= S_NEXT;
                        idx_r <= 2'h0;
                    end
                end
                S_NEXT: begin
                    // lanes left unwritten carry no code and are skipped
                    if (cval_r[idx_r]) begin
                        code_r <= step_code_t'(codes_r[8*idx_r +: 8]);
                        pix_r <= 4'h0;
                        state_r <= S_PIXEL;
                    end else begin
                        idx_r <= idx_r + 2'h1;
                    end
                end
                S_PIXEL: begin
                    if (eligible && (op_r.mmode == MASK_FULL)) state_r <= S_MASK;
                    else if (eligible) state_r <= S_WRITE;
                    else state_r <= S_MOVE;
                end
                S_MASK: begin
                    // one bit per pixel whatever the mask format says
                    if (mask_ack) state_r <= mask_bit ? S_WRITE : S_MOVE;
                end
                S_WRITE: begin
                    if (dst_ready) state_r <= S_MOVE;
                end
                default: begin
                    if (!last_px) begin
                        pix_r <= pix_r + 4'h1;
                        state_r <= S_PIXEL;
                    end else if (is_stop || (idx_r == 2'(STEP_BYTES - 1))) begin
                        state_r <= S_IDLE;
                    end else begin
                        idx_r <= idx_r + 2'h1;
                        state_r <= S_NEXT;
                    end
                end
            endcase
        end
    end

    // destination pointers; software may load them only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_r <= COORD_RST;
            y_r <= COORD_RST;
        end else if (state_r == S_IDLE) begin
            if (apb_wr && (paddr == OFS_DST_X)) x_r <= pwdata[15:0];
            if (apb_wr && (paddr == OFS_DST_Y)) y_r <= pwdata[15:0];
        end else if ((state_r == S_MOVE) && !last_px) begin
            // draw first, then step; no step after the final pixel
            x_r <= x_r + dx_c;
            y_r <= y_r + dy_c;
        end
    end

    // mask coordinate held steady for the duration of a fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mxy_r <= '{x: COORD_RST, y: COORD_RST};
        end else if (state_r == S_PIXEL) begin
            mxy_r <= '{x: mx_c, y: my_c};
        end
    end

    // completion pulse after the last code has run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_done <= 1'b0;
        end else begin
            op_done <= (state_r == S_MOVE) && last_px
                       && (is_stop || (idx_r == 2'(STEP_BYTES - 1)));
        end
    end

    assign busy = (state_r != S_IDLE);
    assign dst_xy = '{x: x_r, y: y_r};
    assign mask_xy = mxy_r;
    assign dst_we = (state_r == S_WRITE);
    assign mask_req = (state_r == S_MASK);

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_msb_start;
        (state_r == S_IDLE) && step_wr && !pstrb[MSB_LANE] |=> !busy;
    endproperty
    a_msb_start: assert property (p_msb_start) else $error("start without top byte");

    property p_wrong_func;
        (state_r == S_IDLE) && step_wr && (op_r.func != FUNC_STEP) |=> !busy;
    endproperty
    a_wrong_func: assert property (p_wrong_func) else $error("ran with wrong function");

    property p_dest_clip;
        dst_we |-> !x_r[15] && !y_r[15] && (x_r <= dst_w_r) && (y_r <= dst_h_r);
    endproperty
    a_dest_clip: assert property (p_dest_clip) else $error("write outside destination");

    property p_mask_zero;
        mask_req && mask_ack && !mask_bit |=> !dst_we ##1 !dst_we;
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("mask 0 pixel written");

    property p_bound_clip;
        dst_we && (op_r.mmode != MASK_OFF) |-> in_mask;
    endproperty
    a_bound_clip: assert property (p_bound_clip) else $error("write outside mask box");

    property p_no_mask_fetch;
        (op_r.mmode != MASK_FULL) |-> !mask_req;
    endproperty
    a_no_mask_fetch: assert property (p_no_mask_fetch) else $error("mask fetched");

    property p_move_only;
        dst_we |-> code_r.draw;
    endproperty
    a_move_only: assert property (p_move_only) else $error("move code wrote a pixel");

    property p_neighbour;
        (state_r == S_MOVE) && !last_px |=> ((x_r != $past(x_r)) || (y_r != $past(y_r)))
            && ((x_r - $past(x_r)) inside {16'h0000, 16'h0001, 16'hFFFF})
            && ((y_r - $past(y_r)) inside {16'h0000, 16'h0001, 16'hFFFF});
    endproperty
    a_neighbour: assert property (p_neighbour) else $error("step not to a neighbour");

    property p_null_ends;
        dst_we |-> !((op_r.dmode == DRAW_FIRST_NULL) && (pix_r == 4'h0))
                   && !((op_r.dmode == DRAW_LAST_NULL) && last_px);
    endproperty
    a_null_ends: assert property (p_null_ends) else $error("null end pixel written");

    property p_stop;
        (state_r == S_MOVE) && last_px && is_stop |=> !busy && op_done;
    endproperty
    a_stop: assert property (p_stop) else $error("stop code did not end");

    property p_hold_end;
        (state_r == S_MOVE) && last_px |=> $stable(x_r) && $stable(y_r);
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("pointer moved past end");

    c_full_mask: cover property (mask_req && mask_ack && mask_bit);
    c_stop_code: cover property ((state_r == S_MOVE) && last_px && is_stop);
    c_four_codes: cover property (op_done && (idx_r == 2'h3));
    c_clipped: cover property ((state_r == S_PIXEL) && code_r.draw && !in_dest);
endmodule // draw_step_engine

`default_nettype wire

// ==== bench/pixel_mem_model.sv ====
/*
 * Memory-side model for the draw-and-step engine: it accepts pixel
 * writes and answers mask fetches from a fixed one-bit mask pattern.
 * Assumes the engine holds each request until it is answered.
 */
`timescale 1ns/100ps
`default_nettype none

module pixel_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic dst_we,
    input wire draw_step_pkg::pix_xy_t mask_xy,
    input wire logic mask_req,
    output logic dst_ready,
    output logic mask_ack,
    output logic mask_bit
);
    import draw_step_pkg::*;
    logic [1:0] wait_r;
    logic junk_r;

    // stall counter, slow mode answers in the third cycle of a request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 2'h0;
        end else if (dst_ready || mask_ack || !(dst_we || mask_req)) begin
            wait_r <= 2'h0;
        end else begin
            wait_r <= wait_r + 2'h1;
        end
    end

    // toggles so a stale mask bit never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            junk_r <= 1'b0;
        end else begin
            junk_r <= ~junk_r;
        end
    end

    // answers: even mask columns open, odd columns closed
    assign dst_ready = dst_we && (!slow || wait_r == 2'h2);
    assign mask_ack = mask_req && (!slow || wait_r == 2'h2);
    assign mask_bit = mask_ack ? ~mask_xy.x[0] : junk_r;
endmodule // pixel_mem_model

`default_nettype wire

// ==== bench/draw_coprocessor_scissor_step_tb.sv ====
/*
 * Self-checking bench for the draw-and-step engine: table of step
 * operations, then busy-time, bus error and reset cases.
 * Assumes the memory model in pixel_mem_model.sv.
 */
`timescale 1ns/100ps
`default_nettype none

module draw_coprocessor_scissor_step_tb;
    import draw_step_pkg::*;
    typedef struct {
        logic [5:0] op;
        int x, y;
        logic [31:0] step;
        logic [3:0] strb;
        bit slow;
        int nwr, ex, ey, w1x, w1y, done;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic slow = 1'b0;
    logic [31:0] prdata, rd_val;
    logic pready, pslverr, dst_we, dst_ready, mask_req, mask_ack, mask_bit;
    logic busy, op_done, rd_err;
    pix_xy_t dst_xy, mask_xy;
    pix_xy_t wr_q[$];
    int fail_count = 0;
    int num_checks = 0;
    int done_cnt = 0;
    int d0, n;
    // op, x, y, codes, strobes, slow, writes, end x, end y, second write, done
    row_t rows[19] = '{
        '{6'h01, 17, 10, 32'h35000000, 4'h8, 0, 6, 22, 5, 18, 9, 1},
        '{6'h01, 30, 30, 32'h05000000, 4'h8, 0, 0, 35, 30, 0, 0, 1},
        '{6'h01, 10, 10, 32'h0000D112, 4'hF, 1, 5, 12, 11, 11, 10, 1},
        '{6'h01, 100, 100, 32'h13130013, 4'hF, 0, 4, 103, 100, 101, 100, 1},
        '{6'h01, 50, 50, 32'h1313FFFF, 4'hC, 1, 8, 56, 50, 51, 50, 1},
        '{6'h00, 60, 60, 32'h13000000, 4'h8, 0, 0, 60, 60, 0, 0, 0},
        '{6'h01, 70, 70, 32'h00131313, 4'h7, 0, 0, 70, 70, 0, 0, 0},
        '{6'h01, -2, 5, 32'h13000000, 4'h8, 0, 2, 1, 5, 1, 5, 1},
        '{6'h01, 4094, 5, 32'h13000000, 4'h8, 0, 2, 4097, 5, 4095, 5, 1},
        '{6'h05, 18, 20, 32'h18000000, 4'h8, 1, 5, 26, 20, 21, 20, 1},
        '{6'h01, 18, 20, 32'h18000000, 4'h8, 0, 9, 26, 20, 19, 20, 1},
        '{6'h09, 18, 20, 32'h18000000, 4'h8, 1, 3, 26, 20, 22, 20, 1},
        '{6'h11, 200, 200, 32'h13130000, 4'hC, 0, 6, 206, 200, 202, 200, 1},
        '{6'h21, 200, 200, 32'h13130000, 4'hC, 1, 6, 206, 200, 201, 200, 1},
        '{6'h01, 300, 300, 32'h51000000, 4'h8, 0, 2, 300, 299, 300, 299, 1},
        '{6'h01, 300, 300, 32'h71000000, 4'h8, 0, 2, 299, 299, 299, 299, 1},
        '{6'h01, 300, 300, 32'h91000000, 4'h8, 0, 2, 299, 300, 299, 300, 1},
        '{6'h01, 300, 300, 32'hB1000000, 4'h8, 0, 2, 299, 301, 299, 301, 1},
        '{6'h01, 300, 300, 32'hF1000000, 4'h8, 0, 2, 301, 301, 301, 301, 1}
    };

    draw_step_engine u_draw_step_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dst_xy(dst_xy),
        .dst_we(dst_we), .dst_ready(dst_ready), .mask_xy(mask_xy), .mask_req(mask_req),
        .mask_ack(mask_ack), .mask_bit(mask_bit), .busy(busy), .op_done(op_done));
    pixel_mem_model u_pixel_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .dst_we(dst_we), .mask_xy(mask_xy), .mask_req(mask_req), .dst_ready(dst_ready),
        .mask_ack(mask_ack), .mask_bit(mask_bit));

    initial begin
        forever #2 pclk = ~pclk;
    end

    // log accepted pixel writes and completion pulses
    always @(posedge pclk) begin
        if (dst_we === 1'b1 && dst_ready === 1'b1) wr_q.push_back(dst_xy);
        if (op_done === 1'b1) done_cnt++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one APB transfer; a spare edge after release keeps strobes apart
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100) begin
            k++;
            @(posedge pclk);
        end
        // a slave that never answers counts against the run
        if (k >= 100) fail_count++;
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // longest path is well under 20000 cycles
    initial begin
        #80000;
        fail_count++;
        results();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(OFS_MSK_W, 1'b1, 32'd4, 4'hF);
        apb(OFS_MSK_H, 1'b1, 32'd4, 4'hF);
        apb(OFS_MSK_OX, 1'b1, 32'd20, 4'hF);
        apb(OFS_MSK_OY, 1'b1, 32'd20, 4'hF);
        foreach (rows[i]) begin
            apb(OFS_OP, 1'b1, {26'h0, rows[i].op}, 4'hF);
            apb(OFS_DST_X, 1'b1, {16'h0, 16'(rows[i].x)}, 4'hF);
            apb(OFS_DST_Y, 1'b1, {16'h0, 16'(rows[i].y)}, 4'hF);
            slow <= rows[i].slow;
            wr_q.delete();
            d0 = done_cnt;
            apb(OFS_STEP, 1'b1, rows[i].step, rows[i].strb);
            n = 0;
            while (done_cnt == d0 && n < 400) begin
                n++;
                @(posedge pclk);
            end
            repeat (2) @(posedge pclk);
            chk("writes", 32'(rows[i].nwr), 32'(wr_q.size()));
            chk("done", 32'(rows[i].done), 32'(done_cnt - d0));
            chk("end xy", {16'(rows[i].ex), 16'(rows[i].ey)}, dst_xy);
            if (rows[i].nwr >= 2) chk("second write", {16'(rows[i].w1x),
                16'(rows[i].w1y)}, wr_q[1]);
        end
        // busy window: pointer and second step writes must be ignored
        apb(OFS_OP, 1'b1, 32'h01, 4'hF);
        apb(OFS_DST_X, 1'b1, 32'd400, 4'hF);
        slow <= 1'b1;
        d0 = done_cnt;
        apb(OFS_STEP, 1'b1, 32'h1F1F1F1F, 4'hF);
        chk("busy", 32'h1, {31'h0, busy});
        apb(OFS_DST_X, 1'b1, 32'd999, 4'hF);
        apb(OFS_STEP, 1'b1, 32'h13000000, 4'h8);
        apb(OFS_STAT, 1'b0, 32'h0, 4'h0);
        chk("status busy", 32'h1, {31'h0, rd_val[STAT_BUSY_BIT]});
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            n++;
            @(posedge pclk);
        end
        repeat (20) @(posedge pclk);
        chk("busy done", 32'h1, 32'(done_cnt - d0));
        chk("busy end x", 32'd460, {16'h0, dst_xy.x});
        // unmapped place answers with an error and zero data
        apb(8'h3C, 1'b0, 32'h0, 4'h0);
        chk("unmapped err", 32'h1, {31'h0, rd_err});
        chk("unmapped data", 32'h0, rd_val);
        // second reset while idle restores register values
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset xy", 32'h0, dst_xy);
        apb(OFS_OP, 1'b0, 32'h0, 4'h0);
        chk("reset op", {26'h0, OP_RST}, rd_val);
        apb(OFS_DST_W, 1'b0, 32'h0, 4'h0);
        chk("reset width", {16'h0, DIM_RST}, rd_val);
        apb(OFS_MSK_OX, 1'b0, 32'h0, 4'h0);
        chk("reset offset", {16'h0, COORD_RST}, rd_val);
        results();
    end
endmodule // draw_coprocessor_scissor_step_tb

`default_nettype wire
